// ===== remote_command_error_queue.sv
// Summary of operation
// (R1) oldest stored error is read first
// (R2) each read reports and removes one error
// (R3) indicator lit while queue not empty
// (R4) one beep pulse per new error
// (R5) full queue: newest entry becomes -350
// (R6) after overflow drop errors until read
// (R7) read of empty queue gives +0
// (R8) clear-status and power-on empty queue
// (R9) reset command leaves queue alone
// (R10) code, comma, quoted text up to 80
// (R11) panel exit or timeout clears queue
// (R12) hash, dollar, percent log -101
// (R13) space around colon or before comma: -102
// (R14) wrong separator logs -103
// (R15) wrong parameter type logs -104
// (R16) trigger mid-string logs -105
// (R17) too many parameters logs -108
// (R18) line feed ends a command string
// (R19) device clear flushes and restarts parsing
// (R20) device clear keeps error queue
// (R21) entry holds signed code and message index
`timescale 1ns/100ps
`default_nettype none
module remote_command_error_queue #(
  parameter logic [31:0] TIMEOUT_CYC = 32'(errq_pkg::TIMEOUT_CYC)
) (
  input wire logic mclk_i, // 100 MHz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic rx_valid_i, // received character strobe
  input wire logic [7:0] rx_data_i, // received character
  input wire logic cmd_str_i, // decoded command wants string
  input wire logic [3:0] cmd_max_par_i, // decoded command max params
  input wire logic get_i, // group execute trigger pulse
  input wire logic dcl_i, // device clear pulse
  input wire logic cls_i, // clear-status command pulse
  input wire logic err_read_i, // error read request pulse
  input wire logic err_key_i, // panel error key pin
  input wire logic knob_i, // panel knob activity pin
  output logic resp_valid_o, // response strobe
  output logic [errq_pkg::CODE_W-1:0] resp_code_o, // signed code
  output logic [errq_pkg::IDX_W-1:0] resp_msg_o, // message index
  output logic [6:0] resp_len_o, // message length in chars
  output logic err_led_o, // error indicator
  output logic beep_o, // beep request pulse
  output logic flush_o, // flush io buffers pulse
  output logic viewing_o, // panel error view active
  output logic [errq_pkg::PTR_W-1:0] count_o // queued entries
);
  typedef enum logic [1:0] {
    P_HDR = 2'b00,
    P_PAR = 2'b01,
    P_SKIP = 2'b10
  } pstate_t;

  typedef struct packed {
    pstate_t pst;
    logic prev_colon;
    logic prev_sp;
    logic tok;
    logic sp_after;
    logic in_str;
    logic [3:0] npar;
    logic mid;
    logic exp_str;
    logic [3:0] max_par;
    logic [errq_pkg::PTR_W-1:0] wr_ptr;
    logic [errq_pkg::PTR_W-1:0] rd_ptr;
    logic [errq_pkg::PTR_W-1:0] cnt;
    logic ovf;
    logic rempty;
    logic rvalid;
    logic beep;
    logic flush;
    logic view;
    logic [31:0] tmr;
    logic [errq_pkg::SYNC_W-1:0] key_s;
    logic [errq_pkg::SYNC_W-1:0] knob_s;
  } st_t;

  st_t s_ff;
  st_t nxt_s;
  logic ev;
  logic signed [errq_pkg::CODE_W-1:0] ev_code;
  logic [errq_pkg::IDX_W-1:0] ev_idx;
  logic mem_we;
  logic [errq_pkg::PTR_W-1:0] mem_waddr;
  logic [errq_pkg::ENT_W-1:0] mem_wdata;
  logic mem_re;
  logic [errq_pkg::ENT_W-1:0] mem_q;
  logic pop;
  logic clr;
  logic key_edge;
  logic knob_edge;

  function automatic logic [errq_pkg::PTR_W-1:0] ptr_inc(
      input logic [errq_pkg::PTR_W-1:0] p);
    ptr_inc = (32'(p) == errq_pkg::DEPTH - 1) ? '0 : p + 5'h01;
  endfunction

  function automatic logic [errq_pkg::PTR_W-1:0] ptr_dec(
      input logic [errq_pkg::PTR_W-1:0] p);
    ptr_dec = (p == '0) ? 5'(errq_pkg::DEPTH - 1) : p - 5'h01;
  endfunction

  function automatic logic is_quote(input logic [7:0] c);
    is_quote = (c == errq_pkg::CH_DQ) || (c == errq_pkg::CH_SQ);
  endfunction

  function automatic logic [6:0] msg_len(input logic [errq_pkg::IDX_W-1:0] i);
    unique case (i)
      errq_pkg::M_NONE: msg_len = 7'h08;
      errq_pkg::M_BADCH: msg_len = 7'h11;
      errq_pkg::M_SYNTAX: msg_len = 7'h0c;
      errq_pkg::M_SEP: msg_len = 7'h11;
      errq_pkg::M_TYPE: msg_len = 7'h0f;
      errq_pkg::M_GET: msg_len = 7'h0f;
      errq_pkg::M_XPAR: msg_len = 7'h15;
      errq_pkg::M_OVF: msg_len = 7'h0f;
    endcase
  endfunction

  // edges come from the second stage and a delay copy, never the first stage
  assign key_edge = s_ff.key_s[1] & ~s_ff.key_s[2];
  assign knob_edge = s_ff.knob_s[1] ^ s_ff.knob_s[2];

  always_comb begin
    nxt_s = s_ff;
    ev = 1'b0;
    ev_code = errq_pkg::C_NONE;
    ev_idx = errq_pkg::M_NONE;
    mem_we = 1'b0;
    mem_waddr = s_ff.wr_ptr;
    mem_wdata = '0;
    mem_re = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    nxt_s.beep = 1'b0;
    nxt_s.rvalid = 1'b0;
    nxt_s.flush = 1'b0;
    nxt_s.key_s = {s_ff.key_s[1:0], err_key_i};
    nxt_s.knob_s = {s_ff.knob_s[1:0], knob_i};

    // ---------------- parser ----------------
    if (rx_valid_i) begin
      nxt_s.mid = 1'b1;
      nxt_s.prev_colon = 1'b0;
      nxt_s.prev_sp = 1'b0;
      if (rx_data_i == errq_pkg::CH_LF) begin
        nxt_s.pst = P_HDR; // R18
        nxt_s.mid = 1'b0;
        nxt_s.tok = 1'b0;
        nxt_s.sp_after = 1'b0;
        nxt_s.in_str = 1'b0;
        nxt_s.npar = '0;
      end else if (s_ff.in_str) begin
        // strings may carry any character except line feed and the quote marks, either of which closes them
        if (is_quote(rx_data_i)) begin
          nxt_s.in_str = 1'b0;
        end
      end else if (s_ff.pst != P_SKIP && (rx_data_i == errq_pkg::CH_HASH ||
          rx_data_i == errq_pkg::CH_DOLLAR || rx_data_i == errq_pkg::CH_PCT)) begin
        ev = 1'b1; // R12
        ev_code = errq_pkg::C_BADCH;
        ev_idx = errq_pkg::M_BADCH;
      end else begin
        unique case (s_ff.pst)
          P_HDR: begin
            if (rx_data_i == errq_pkg::CH_COLON) begin
              nxt_s.prev_colon = 1'b1;
            end else if (rx_data_i == errq_pkg::CH_SP) begin
              if (s_ff.prev_colon) begin
                ev = 1'b1; // R13
                ev_code = errq_pkg::C_SYNTAX;
                ev_idx = errq_pkg::M_SYNTAX;
              end else begin
                nxt_s.pst = P_PAR;
                nxt_s.prev_sp = 1'b1;
                nxt_s.exp_str = cmd_str_i;
                nxt_s.max_par = cmd_max_par_i;
              end
            end else if (rx_data_i == errq_pkg::CH_COMMA) begin
              ev = 1'b1; // R14
              ev_code = errq_pkg::C_SEP;
              ev_idx = errq_pkg::M_SEP;
            end
          end
          P_PAR: begin
            if (rx_data_i == errq_pkg::CH_SEMI) begin
              nxt_s.pst = P_HDR;
              nxt_s.tok = 1'b0;
              nxt_s.sp_after = 1'b0;
              nxt_s.npar = '0;
            end else if (s_ff.prev_sp && !s_ff.tok && s_ff.npar == '0 &&
                (rx_data_i == errq_pkg::CH_COLON || rx_data_i == errq_pkg::CH_COMMA)) begin
              ev = 1'b1; // R13
              ev_code = errq_pkg::C_SYNTAX;
              ev_idx = errq_pkg::M_SYNTAX;
            end else if (rx_data_i == errq_pkg::CH_SP) begin
              nxt_s.prev_sp = 1'b1;
              if (s_ff.tok) begin
                nxt_s.sp_after = 1'b1;
              end
            end else if (rx_data_i == errq_pkg::CH_COMMA) begin
              if (s_ff.sp_after) begin
                ev = 1'b1; // R13
                ev_code = errq_pkg::C_SYNTAX;
                ev_idx = errq_pkg::M_SYNTAX;
              end else begin
                nxt_s.tok = 1'b0;
              end
            end else if (s_ff.sp_after) begin
              ev = 1'b1; // R14
              ev_code = errq_pkg::C_SEP;
              ev_idx = errq_pkg::M_SEP;
            end else if (!s_ff.tok) begin
              nxt_s.tok = 1'b1;
              nxt_s.npar = s_ff.npar + 4'h1;
              if (s_ff.npar >= s_ff.max_par) begin
                ev = 1'b1; // R17
                ev_code = errq_pkg::C_XPAR;
                ev_idx = errq_pkg::M_XPAR;
              end else if (is_quote(rx_data_i) != s_ff.exp_str) begin
                ev = 1'b1; // R15
                ev_code = errq_pkg::C_TYPE;
                ev_idx = errq_pkg::M_TYPE;
              end else begin
                nxt_s.in_str = is_quote(rx_data_i);
              end
            end
          end
          P_SKIP: begin
            // rest of a faulty string is dropped up to its line feed
          end
          default: nxt_s.pst = P_SKIP;
        endcase
      end
    end
    // a trigger inside a partial string outranks a character error
    if (get_i && (s_ff.mid || rx_valid_i)) begin
      ev = 1'b1; // R16
      ev_code = errq_pkg::C_GET;
      ev_idx = errq_pkg::M_GET;
    end
    // one parser error per command string; a trigger can still log -105
    if (ev && !(rx_valid_i && rx_data_i == errq_pkg::CH_LF)) begin
      nxt_s.pst = P_SKIP;
      nxt_s.in_str = 1'b0;
    end
    if (dcl_i) begin
      nxt_s.pst = P_HDR; // R19
      nxt_s.mid = 1'b0;
      nxt_s.tok = 1'b0;
      nxt_s.sp_after = 1'b0;
      nxt_s.in_str = 1'b0;
      nxt_s.npar = '0;
      nxt_s.prev_colon = 1'b0;
      nxt_s.prev_sp = 1'b0;
      nxt_s.flush = 1'b1; // R19
      // queue state is deliberately left out of this branch (R20)
    end

    // ---------------- front panel view ----------------
    clr = cls_i; // R8
    if (!s_ff.view) begin
      if (key_edge && s_ff.cnt != '0) begin
        nxt_s.view = 1'b1;
        nxt_s.tmr = '0;
      end
    end else if (key_edge || s_ff.tmr >= TIMEOUT_CYC - 32'h1) begin
      nxt_s.view = 1'b0; // R11
      clr = 1'b1; // R11
    end else if (knob_edge) begin
      nxt_s.tmr = '0;
    end else begin
      nxt_s.tmr = s_ff.tmr + 32'h1;
    end

    // ---------------- queue ----------------
    if (err_read_i) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rempty = (s_ff.cnt == '0); // R7
      if (s_ff.cnt != '0) begin
        mem_re = 1'b1; // R1
        pop = 1'b1; // R2
        nxt_s.rd_ptr = ptr_inc(s_ff.rd_ptr); // R2
        nxt_s.ovf = 1'b0; // R6
      end
    end
    nxt_s.cnt = s_ff.cnt - 5'(pop);
    if (ev) begin
      nxt_s.beep = 1'b1; // R4
      if (32'(nxt_s.cnt) < errq_pkg::DEPTH) begin
        mem_we = 1'b1;
        mem_wdata = {ev_code, ev_idx}; // R21
        nxt_s.wr_ptr = ptr_inc(s_ff.wr_ptr); // R1
        nxt_s.cnt = nxt_s.cnt + 5'h01;
      end else if (!s_ff.ovf) begin
        mem_we = 1'b1; // R5
        mem_waddr = ptr_dec(s_ff.wr_ptr); // R5
        mem_wdata = {errq_pkg::C_OVF, errq_pkg::M_OVF}; // R5
        nxt_s.ovf = 1'b1; // R6
      end
    end
    // clear wins over a same-cycle error; reset command has no path here (R9)
    if (clr) begin
      mem_we = 1'b0;
      nxt_s.wr_ptr = '0;
      nxt_s.rd_ptr = '0;
      nxt_s.cnt = '0;
      nxt_s.ovf = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0; // R8
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  errq_mem #(
    .W(errq_pkg::ENT_W),
    .DEPTH(errq_pkg::DEPTH),
    .AW(errq_pkg::PTR_W)
  ) u_mem (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .re_i(mem_re),
    .raddr_i(s_ff.rd_ptr),
    .rdata_o(mem_q)
  );

  // selection by the rempty flop: held memory word or the constant empty marker
  assign resp_valid_o = s_ff.rvalid;
  assign resp_code_o = s_ff.rempty ? errq_pkg::C_NONE : mem_q[errq_pkg::ENT_W-1:errq_pkg::IDX_W];
  assign resp_msg_o = s_ff.rempty ? errq_pkg::M_NONE : mem_q[errq_pkg::IDX_W-1:0];
  assign resp_len_o = msg_len(resp_msg_o); // R10
  assign err_led_o = (s_ff.cnt != '0); // R3
  assign beep_o = s_ff.beep;
  assign flush_o = s_ff.flush;
  assign viewing_o = s_ff.view;
  assign count_o = s_ff.cnt;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  read_answer_a: assert property (ce_i && err_read_i |=> resp_valid_o) // R2
    else $error("read got no answer");
  pop_count_a: assert property (ce_i && err_read_i && s_ff.cnt != '0 && !ev && !clr
      |=> s_ff.cnt == $past(s_ff.cnt) - 5'h01) // R2
    else $error("read did not remove one entry");
  empty_read_a: assert property (ce_i && err_read_i && s_ff.cnt == '0
      |=> resp_code_o == errq_pkg::C_NONE && resp_msg_o == errq_pkg::M_NONE) // R7
    else $error("empty read not plus zero");
  beep_once_a: assert property (ce_i && ev |=> beep_o ##1 (!beep_o || $past(ev))) // R4
    else $error("beep not a single pulse");
  overflow_mark_a: assert property (ce_i && ev && s_ff.cnt == 5'(errq_pkg::DEPTH) &&
      !s_ff.ovf && !err_read_i && !clr |-> mem_we && mem_wdata[errq_pkg::ENT_W-1:errq_pkg::IDX_W]
      == errq_pkg::C_OVF ##1 s_ff.ovf && s_ff.cnt == 5'(errq_pkg::DEPTH)) // R5
    else $error("overflow not marked");
  overflow_drop_a: assert property (s_ff.ovf && ev && !err_read_i && !clr |-> !mem_we) // R6
    else $error("error stored during overflow");
  status_clear_a: assert property (ce_i && cls_i |=> s_ff.cnt == '0 && !err_led_o) // R8
    else $error("clear-status left entries");
  devclr_keep_a: assert property (ce_i && dcl_i && !ev && !err_read_i && !clr
      |=> $stable(s_ff.cnt) && flush_o) // R20
    else $error("device clear touched queue");
  bad_char_a: assert property (rx_valid_i && s_ff.pst == P_HDR && !s_ff.in_str && !get_i &&
      rx_data_i == errq_pkg::CH_HASH |-> ev && ev_code == errq_pkg::C_BADCH) // R12
    else $error("bad character not logged");
  trig_mid_a: assert property (ce_i && get_i && s_ff.mid |=> beep_o) // R16
    else $error("trigger mid-string not logged");

  cov_overflow: cover property (s_ff.ovf && ev);
  cov_empty_read: cover property (err_read_i && s_ff.cnt == '0);
  cov_timeout: cover property (s_ff.view && clr && !key_edge);
  cov_full_read: cover property (err_read_i && s_ff.cnt == 5'(errq_pkg::DEPTH));
endmodule // remote_command_error_queue
`default_nettype wire

// ===== errq_pkg.sv
package errq_pkg;
  localparam int CODE_W = 10;
  localparam int IDX_W = 3;
  localparam int ENT_W = CODE_W + IDX_W;
  localparam int DEPTH = 20;
  localparam int PTR_W = 5;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_DQ = 8'h22;
  localparam logic [7:0] CH_SQ = 8'h27;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic signed [CODE_W-1:0] C_NONE = 10'sd0;
  localparam logic signed [CODE_W-1:0] C_BADCH = -10'sd101;
  localparam logic signed [CODE_W-1:0] C_SYNTAX = -10'sd102;
  localparam logic signed [CODE_W-1:0] C_SEP = -10'sd103;
  localparam logic signed [CODE_W-1:0] C_TYPE = -10'sd104;
  localparam logic signed [CODE_W-1:0] C_GET = -10'sd105;
  localparam logic signed [CODE_W-1:0] C_XPAR = -10'sd108;
  localparam logic signed [CODE_W-1:0] C_OVF = -10'sd350;
  localparam logic [IDX_W-1:0] M_NONE = 3'h0;
  localparam logic [IDX_W-1:0] M_BADCH = 3'h1;
  localparam logic [IDX_W-1:0] M_SYNTAX = 3'h2;
  localparam logic [IDX_W-1:0] M_SEP = 3'h3;
  localparam logic [IDX_W-1:0] M_TYPE = 3'h4;
  localparam logic [IDX_W-1:0] M_GET = 3'h5;
  localparam logic [IDX_W-1:0] M_XPAR = 3'h6;
  localparam logic [IDX_W-1:0] M_OVF = 3'h7;
  localparam int MSG_MAX = 80;
  localparam int TIMEOUT_SEC = 30;
  localparam longint CLK_HZ = 64'd100_000_000;
  localparam longint TIMEOUT_CYC = 64'(TIMEOUT_SEC) * CLK_HZ;
  localparam int SYNC_W = 3;
endpackage

// ===== errq_mem.sv
`timescale 1ns/100ps
`default_nettype none
module errq_mem #(
  parameter int W = 13,
  parameter int DEPTH = 20,
  parameter int AW = 5
) (
  input wire logic mclk_i, // system clock
  input wire logic rst_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic we_i, // write strobe
  input wire logic [AW-1:0] waddr_i, // write address
  input wire logic [W-1:0] wdata_i, // write data
  input wire logic re_i, // read strobe
  input wire logic [AW-1:0] raddr_i, // read address
  output logic [W-1:0] rdata_o // registered read data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } mem_st_t;

  mem_st_t s_ff;
  mem_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (re_i && 32'(raddr_i) < DEPTH) begin
      nxt_s.rdata = s_ff.mem[raddr_i];
    end
    if (we_i && 32'(waddr_i) < DEPTH) begin
      nxt_s.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rdata;
endmodule // errq_mem
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic mclk_i, // system clock
  output logic rx_valid_o, // character strobe
  output logic [7:0] rx_data_o // character
);
  logic [7:0] last_ff;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    last_ff = 8'h00;
  end

  // gap idles between characters to model a slow host
  task automatic send(input string s, input int gap = 0);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge mclk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= s[i];
      last_ff <= s[i];
      for (int g = 0; g < gap; g++) begin
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~s[i];
      end
    end
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    // data not qualified: never leave the last char for the sim to reuse
    rx_data_o <= ~last_ff;
  endtask
endmodule // host_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk_i, rst_n_i, ce_i, rx_valid_i, cmd_str_i, get_i, dcl_i, cls_i;
  logic err_read_i, err_key_i, knob_i;
  logic [7:0] rx_data_i;
  logic [3:0] cmd_max_par_i;
  logic resp_valid_o, err_led_o, beep_o, flush_o, viewing_o;
  logic [errq_pkg::CODE_W-1:0] resp_code_o;
  logic [errq_pkg::IDX_W-1:0] resp_msg_o;
  logic [6:0] resp_len_o;
  logic [errq_pkg::PTR_W-1:0] count_o;
  int err_count, total_checks, beeps, cycles, b0;
  localparam int LEN_TAB [8] = '{8, 17, 12, 17, 15, 15, 21, 15};

  remote_command_error_queue #(.TIMEOUT_CYC(32'd50)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .cmd_str_i(cmd_str_i), .cmd_max_par_i(cmd_max_par_i),
    .get_i(get_i), .dcl_i(dcl_i), .cls_i(cls_i), .err_read_i(err_read_i),
    .err_key_i(err_key_i), .knob_i(knob_i), .resp_valid_o(resp_valid_o),
    .resp_code_o(resp_code_o), .resp_msg_o(resp_msg_o), .resp_len_o(resp_len_o),
    .err_led_o(err_led_o), .beep_o(beep_o), .flush_o(flush_o),
    .viewing_o(viewing_o), .count_o(count_o));

  host_model u_host (.mclk_i(mclk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (beep_o === 1'b1) beeps <= beeps + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // sel: 0 read, 1 trigger, 2 device clear, 3 clear-status
  task automatic pulse(input int sel);
    @(posedge mclk_i);
    err_read_i <= (sel == 0);
    get_i <= (sel == 1);
    dcl_i <= (sel == 2);
    cls_i <= (sel == 3);
    @(posedge mclk_i);
    err_read_i <= 1'b0;
    get_i <= 1'b0;
    dcl_i <= 1'b0;
    cls_i <= 1'b0;
  endtask

  task automatic read_err(input logic [9:0] code, input logic [2:0] msg);
    pulse(0);
    #1;
    check("resp_valid", 10'(resp_valid_o), 10'h001);
    check("resp_code", resp_code_o, code);
    check("resp_msg", 10'(resp_msg_o), 10'(msg));
    check("resp_len", 10'(resp_len_o), 10'(LEN_TAB[msg]));
  endtask

  task automatic cmd(input string s, input logic str, input logic [3:0] maxp, input int gap = 0);
    cmd_str_i <= str;
    cmd_max_par_i <= maxp;
    u_host.send(s, gap);
    repeat (2) @(posedge mclk_i);
    #1;
  endtask

  task automatic t_empty();
    check("count", 10'(count_o), 10'h000);
    check("led", 10'(err_led_o), 10'h000);
    read_err(errq_pkg::C_NONE, errq_pkg::M_NONE);
    check("count", 10'(count_o), 10'h000);
    $display("test empty done");
  endtask

  task automatic t_codes();
    string s [5] = '{"OUTP:STAT #ON\n", "VOLT: LEV 1\n", "TRIG,SOUR BUS\n",
                     "DISP:TEXT 123\n", "OUTP 1\n"};
    logic st [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [3:0] mp [5] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h0};
    logic [9:0] cd [6] = '{errq_pkg::C_BADCH, errq_pkg::C_SYNTAX, errq_pkg::C_SEP,
                           errq_pkg::C_TYPE, errq_pkg::C_XPAR, errq_pkg::C_GET};
    logic [2:0] mi [6] = '{errq_pkg::M_BADCH, errq_pkg::M_SYNTAX, errq_pkg::M_SEP,
                           errq_pkg::M_TYPE, errq_pkg::M_XPAR, errq_pkg::M_GET};
    b0 = beeps;
    for (int i = 0; i < 5; i++) cmd(s[i], st[i], mp[i], i % 2);
    u_host.send("VOLT");
    pulse(1);
    cmd("\n", 1'b0, 4'h1);
    check("count", 10'(count_o), 10'h006);
    check("beeps", 10'(beeps - b0), 10'h006);
    check("led", 10'(err_led_o), 10'h001);
    for (int i = 0; i < 6; i++) begin
      read_err(cd[i], mi[i]);
      check("count", 10'(count_o), 10'(5 - i));
    end
    check("led", 10'(err_led_o), 10'h000);
    $display("test codes done");
  endtask

  task automatic t_overflow();
    b0 = beeps;
    for (int i = 0; i < 22; i++) cmd("X #\n", 1'b0, 4'h1);
    check("count", 10'(count_o), 10'h014);
    check("beeps", 10'(beeps - b0), 10'h016);
    read_err(errq_pkg::C_BADCH, errq_pkg::M_BADCH);
    cmd("VOLT: X\n", 1'b0, 4'h1);
    check("count", 10'(count_o), 10'h014);
    for (int i = 0; i < 18; i++) read_err(errq_pkg::C_BADCH, errq_pkg::M_BADCH);
    read_err(errq_pkg::C_OVF, errq_pkg::M_OVF);
    read_err(errq_pkg::C_SYNTAX, errq_pkg::M_SYNTAX);
    check("count", 10'(count_o), 10'h000);
    $display("test overflow done");
  endtask

  task automatic t_clear();
    cmd("X #\n", 1'b0, 4'h1);
    cmd("X %\n", 1'b0, 4'h1);
    // left inside a quoted string, where a hash is legal
    cmd_str_i <= 1'b1;
    u_host.send("DISP:TEXT 'a");
    pulse(2);
    #1;
    check("flush", 10'(flush_o), 10'h001);
    check("count", 10'(count_o), 10'h002);
    cmd("X#\n", 1'b1, 4'h1);
    check("count", 10'(count_o), 10'h003);
    // frozen clock enable must swallow the clear-status pulse
    ce_i <= 1'b0;
    pulse(3);
    #1;
    check("count", 10'(count_o), 10'h003);
    ce_i <= 1'b1;
    pulse(3);
    #1;
    check("count", 10'(count_o), 10'h000);
    check("led", 10'(err_led_o), 10'h000);
    $display("test clear done");
  endtask

  task automatic press_key(input logic exp);
    err_key_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    err_key_i <= 1'b0;
    // pin must be seen low before the next press makes a fresh edge
    repeat (4) @(posedge mclk_i);
    #1;
    check("viewing", 10'(viewing_o), 10'(exp));
  endtask

  task automatic t_panel();
    cmd("X $\n", 1'b0, 4'h1);
    press_key(1'b1);
    for (int i = 0; i < 3; i++) begin
      repeat (30) @(posedge mclk_i);
      knob_i <= ~knob_i;
    end
    #1;
    check("viewing", 10'(viewing_o), 10'h001);
    check("count", 10'(count_o), 10'h001);
    for (int i = 0; i < 80 && viewing_o !== 1'b0; i++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    #1;
    check("viewing", 10'(viewing_o), 10'h000);
    check("count", 10'(count_o), 10'h000);
    cmd("X $\n", 1'b0, 4'h1);
    press_key(1'b1);
    press_key(1'b0);
    repeat (3) @(posedge mclk_i);
    #1;
    check("count", 10'(count_o), 10'h000);
    $display("test panel done");
  endtask

  initial begin
    err_count = 0;
    total_checks = 0;
    beeps = 0;
    cycles = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    cmd_str_i = 1'b0;
    cmd_max_par_i = 4'h1;
    get_i = 1'b0;
    dcl_i = 1'b0;
    cls_i = 1'b0;
    err_read_i = 1'b0;
    err_key_i = 1'b0;
    knob_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    t_empty();
    t_codes();
    t_overflow();
    t_clear();
    t_panel();
    test_done();
  end
endmodule // testbench
`default_nettype wire
